// File: teach_diag_pkg.sv
// Constants, encodings and timing counts shared by the teach and diagnostic logic.
// Assumes a single 200 MHz clock; no register bus, all settings arrive as ports.
// Operation
// - Two button modes, expert default, set externally
// - Expert mode: field limits, zero, factory reset
// - Quick mode: zero position teach only
// - Button locks after timeout, default five minutes
// - Quick: two-second hold starts teach, 2 Hz
// - Teach success stores zero, returns to normal
// - Teach failure blinks green and yellow 8 Hz
// - Timeout counted from teach end; zero never locks
// - Timeout 255 locks button permanently
// - Report completed measurements per second
// - Output updates once per completed measurement
// - Rate and delay follow adaptive exposure time
// - Report trigger-to-output response delay
// - Response delay excludes any filter term
// - Report exposure reserve as unitless value
// - Quality: 0 valid, 1 weak, 2 critical
// - LEDs blink when quality is critical
// - Alarm asserted when no value obtained
// - Health: 0 ok, 1 maintenance, 2 no value
package teach_diag_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Timing in own units, cycle counts derived
  localparam int unsigned HOLD_TIME_MS = 2000;
  localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned TEACH_BLINK_HZ = 2;
  localparam int unsigned TEACH_HALF_CYCLES = CLK_HZ / (2 * TEACH_BLINK_HZ);
  localparam int unsigned FAIL_BLINK_HZ = 8;
  localparam int unsigned FAIL_HALF_CYCLES = CLK_HZ / (2 * FAIL_BLINK_HZ);
  localparam int unsigned CRIT_BLINK_HZ = 2;
  localparam int unsigned CRIT_HALF_CYCLES = CLK_HZ / (2 * CRIT_BLINK_HZ);
  localparam longint unsigned MINUTE_S = 60;
  localparam longint unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;
  localparam int unsigned SECOND_CYCLES = CLK_HZ;
  localparam int unsigned FAIL_SHOW_MS = 2000;
  localparam int unsigned FAIL_SHOW_CYCLES = FAIL_SHOW_MS * (CLK_HZ / 1000);

  // Lock timeout codes
  localparam logic [7:0] LOCK_DEFAULT_MIN = 8'h05;
  localparam logic [7:0] LOCK_NEVER = 8'h00;
  localparam logic [7:0] LOCK_ALWAYS = 8'hFF;

  // Widths
  localparam int unsigned DIST_W = 16;
  localparam int unsigned RESERVE_W = 8;
  localparam int unsigned RATE_W = 16;
  localparam int unsigned DELAY_W = 32;

  typedef enum logic
  {
    MODE_EXPERT = 1'b0,
    MODE_QUICK = 1'b1
  } teach_mode_type;

  typedef enum logic [1:0]
  {
    QUAL_VALID = 2'h0,
    QUAL_WEAK = 2'h1,
    QUAL_CRITICAL = 2'h2
  } quality_type;

  typedef enum logic [1:0]
  {
    HEALTH_OK = 2'h0,
    HEALTH_MAINT = 2'h1,
    HEALTH_NO_VALUE = 2'h2
  } health_type;

  // Expert-mode button requests
  typedef enum logic [1:0]
  {
    REQ_NONE = 2'h0,
    REQ_FIELD = 2'h1,
    REQ_ZERO = 2'h2,
    REQ_FACTORY = 2'h3
  } expert_req_type;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_TEACH = 2'b11,
    ST_FAIL = 2'b10
  } teach_state_type;

endpackage

// File: blink_gen.sv
// Free-running square wave with a programmable half period.
// Assumes clk/rstn of the teach block; restarts low when disabled.
`timescale 1ns/1ps
module blink_gen #(
  parameter int unsigned HALF_CYCLES = 50_000_000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic enable,
  output logic wave
);

  localparam int unsigned CW = $clog2(HALF_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

  logic [CW-1:0] count_q;
  logic phase_q;
  wire wrap = (count_q == LAST);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_q <= '0;
      phase_q <= 1'b0;
    end
    else if (!enable)
    begin
      count_q <= '0;
      phase_q <= 1'b0;
    end
    else if (wrap)
    begin
      count_q <= '0;
      phase_q <= ~phase_q;
    end
    else
    begin
      count_q <= count_q + 1'b1;
    end
  end

  assign wave = phase_q;

endmodule

// File: meas_diag.sv
// Measurement diagnostics: rate per second, response delay, reserve, quality, health.
// Assumes trigger and done pulses come from same-clock measurement logic.
`timescale 1ns/1ps
module meas_diag #(
  parameter int unsigned SECOND_CYCLES = teach_diag_pkg::SECOND_CYCLES,
  parameter int unsigned DIST_W = teach_diag_pkg::DIST_W,
  parameter int unsigned RESERVE_W = teach_diag_pkg::RESERVE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Measurement side
  input wire logic measTrigger,
  input wire logic measDone,
  input wire logic measValid,
  input wire logic [DIST_W-1:0] measDistance,
  input wire logic [RESERVE_W-1:0] measReserve,
  input wire logic [RESERVE_W-1:0] weakLimit,
  input wire logic [RESERVE_W-1:0] criticalLimit,
  // Reports
  output logic [DIST_W-1:0] outValue,
  output logic outUpdate,
  output logic [teach_diag_pkg::RATE_W-1:0] measurementRateValue,
  output logic [teach_diag_pkg::DELAY_W-1:0] responseDelayValue,
  output logic [RESERVE_W-1:0] exposureReserve,
  output teach_diag_pkg::quality_type signalQuality,
  output teach_diag_pkg::health_type deviceHealthStatus,
  output logic alarmOut
);

  localparam int unsigned SW = $clog2(SECOND_CYCLES + 1);
  localparam logic [SW-1:0] SEC_LAST = SW'(SECOND_CYCLES - 1);

  logic [SW-1:0] secCount_q;
  logic [teach_diag_pkg::RATE_W-1:0] rateCount_q;
  logic [teach_diag_pkg::DELAY_W-1:0] delayCount_q;
  logic secWrap;
  teach_diag_pkg::quality_type quality_d;

  assign secWrap = (secCount_q == SEC_LAST);
  // Reserve thresholds give the quality class
  assign quality_d = (measReserve <= criticalLimit) ? teach_diag_pkg::QUAL_CRITICAL :
                     (measReserve <= weakLimit) ? teach_diag_pkg::QUAL_WEAK : teach_diag_pkg::QUAL_VALID;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      secCount_q <= '0;
      rateCount_q <= '0;
      measurementRateValue <= '0;
    end
    else
    begin
      secCount_q <= secWrap ? '0 : secCount_q + 1'b1;
      if (secWrap)
      begin
        // Completed measurements in the last second
        measurementRateValue <= rateCount_q + {{(teach_diag_pkg::RATE_W-1){1'b0}}, measDone};
        rateCount_q <= '0;
      end
      else if (measDone && rateCount_q != '1)
      begin
        rateCount_q <= rateCount_q + 1'b1;
      end
    end
  end

  // Trigger to output change; filter stage sits elsewhere and is not counted
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      delayCount_q <= '0;
      responseDelayValue <= '0;
    end
    else if (measTrigger)
    begin
      delayCount_q <= '0;
    end
    else if (measDone)
    begin
      responseDelayValue <= delayCount_q + 1'b1;
    end
    else if (delayCount_q != '1)
    begin
      delayCount_q <= delayCount_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      outValue <= '0;
      outUpdate <= 1'b0;
      exposureReserve <= '0;
      signalQuality <= teach_diag_pkg::QUAL_VALID;
      deviceHealthStatus <= teach_diag_pkg::HEALTH_OK;
      alarmOut <= 1'b0;
    end
    else
    begin
      outUpdate <= measDone;
      if (measDone)
      begin
        if (measValid)
        begin
          outValue <= measDistance;
        end
        exposureReserve <= measReserve;
        signalQuality <= quality_d;
        alarmOut <= ~measValid;
        if (!measValid)
        begin
          deviceHealthStatus <= teach_diag_pkg::HEALTH_NO_VALUE;
        end
        else if (quality_d == teach_diag_pkg::QUAL_CRITICAL)
        begin
          deviceHealthStatus <= teach_diag_pkg::HEALTH_MAINT;
        end
        else
        begin
          deviceHealthStatus <= teach_diag_pkg::HEALTH_OK;
        end
      end
    end
  end

endmodule

// File: teach_button_and_diagnostic_status.sv
// Teach button handling, LED indication and diagnostic status of the distance sensor.
// Assumes a raw button pin (async, active low), same-clock measurement pulses
// and parameter values held stable by the IO-Link parameter logic.
`timescale 1ns/1ps
module teach_button_and_diagnostic_status #(
  parameter int unsigned HOLD_CYCLES = teach_diag_pkg::HOLD_CYCLES,
  parameter longint unsigned MINUTE_CYCLES = teach_diag_pkg::MINUTE_CYCLES,
  parameter int unsigned SECOND_CYCLES = teach_diag_pkg::SECOND_CYCLES,
  parameter int unsigned FAIL_SHOW_CYCLES = teach_diag_pkg::FAIL_SHOW_CYCLES,
  parameter int unsigned TEACH_HALF_CYCLES = teach_diag_pkg::TEACH_HALF_CYCLES,
  parameter int unsigned FAIL_HALF_CYCLES = teach_diag_pkg::FAIL_HALF_CYCLES,
  parameter int unsigned CRIT_HALF_CYCLES = teach_diag_pkg::CRIT_HALF_CYCLES,
  parameter int unsigned DIST_W = teach_diag_pkg::DIST_W,
  parameter int unsigned RESERVE_W = teach_diag_pkg::RESERVE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Push button pin
  input wire logic buttonPin_n,
  // Parameters from the IO-Link side
  input wire logic paramModeQuick,
  input wire logic paramModeWrite,
  input wire logic [7:0] paramLockTimeout,
  input wire logic paramLockWrite,
  input wire logic [RESERVE_W-1:0] weakLimit,
  input wire logic [RESERVE_W-1:0] criticalLimit,
  // Measurement side
  input wire logic measTrigger,
  input wire logic measDone,
  input wire logic measValid,
  input wire logic [DIST_W-1:0] measDistance,
  input wire logic [RESERVE_W-1:0] measReserve,
  // Teach results
  output teach_diag_pkg::teach_mode_type teachMode,
  output logic [7:0] lockTimeout,
  output logic buttonEnabled,
  output logic [DIST_W-1:0] zeroPosition,
  output logic zeroStored,
  output teach_diag_pkg::expert_req_type expertRequest,
  output logic expertRequestValid,
  output logic teachBusy,
  // LEDs
  output logic ledGreen,
  output logic ledYellow,
  // Diagnostics
  output logic [DIST_W-1:0] outValue,
  output logic outUpdate,
  output logic [teach_diag_pkg::RATE_W-1:0] measurementRateValue,
  output logic [teach_diag_pkg::DELAY_W-1:0] responseDelayValue,
  output logic [RESERVE_W-1:0] exposureReserve,
  output teach_diag_pkg::quality_type signalQuality,
  output teach_diag_pkg::health_type deviceHealthStatus,
  output logic alarmOut
);

  localparam int unsigned HW = $clog2(HOLD_CYCLES * 4 + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
  localparam logic [HW-1:0] HOLD2_LAST = HW'(HOLD_CYCLES * 2 - 1);
  localparam logic [HW-1:0] HOLD3_LAST = HW'(HOLD_CYCLES * 3 - 1);

  localparam int unsigned MW = $clog2(MINUTE_CYCLES + 1);
  localparam logic [MW-1:0] MIN_LAST = MW'(MINUTE_CYCLES - 1);

  localparam int unsigned FW = $clog2(FAIL_SHOW_CYCLES + 1);
  localparam logic [FW-1:0] FAIL_LAST = FW'(FAIL_SHOW_CYCLES - 1);

  // Button synchroniser; first stage feeds only the second
  logic btnMeta_q;
  logic btnSync_q;

  logic pressed;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      btnMeta_q <= 1'b0;
      btnSync_q <= 1'b0;
    end
    else
    begin
      btnMeta_q <= ~buttonPin_n;
      btnSync_q <= btnMeta_q;
    end
  end

  assign pressed = btnSync_q;

  // Mode and timeout settings, changed only by the parameter side
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      teachMode <= teach_diag_pkg::MODE_EXPERT;
      lockTimeout <= teach_diag_pkg::LOCK_DEFAULT_MIN;
    end
    else
    begin
      if (paramModeWrite)
      begin
        teachMode <= paramModeQuick ? teach_diag_pkg::MODE_QUICK :
                     teach_diag_pkg::MODE_EXPERT;
      end
      if (paramLockWrite)
      begin
        lockTimeout <= paramLockTimeout;
      end
    end
  end

  // Teach sequencer
  teach_diag_pkg::teach_state_type state_q;
  teach_diag_pkg::teach_state_type state_d;
  logic [HW-1:0] holdCount_q;
  logic [FW-1:0] failCount_q;

  logic teachEnd;
  logic releaseEdge;
  logic pressedPrev_q;

  logic quickMode;
  logic holdReached;

  assign quickMode = (teachMode == teach_diag_pkg::MODE_QUICK);
  assign releaseEdge = pressedPrev_q & ~pressed;
  assign holdReached = (holdCount_q == HOLD_LAST);

  // Count saturates on an endless press
  wire holdStep = (state_q == teach_diag_pkg::ST_HOLD) && pressed;

  // Expert mode: hold length selects the function on release
  wire expertFn1 = (holdCount_q >= HOLD_LAST) && (holdCount_q < HOLD2_LAST);
  wire expertFn2 = (holdCount_q >= HOLD2_LAST) && (holdCount_q < HOLD3_LAST);
  wire expertFn3 = (holdCount_q >= HOLD3_LAST);
  wire expertFire = releaseEdge && !quickMode && buttonEnabled &&
                    (expertFn1 || expertFn2 || expertFn3);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      teach_diag_pkg::ST_IDLE:
        if (pressed && buttonEnabled)
        begin
          state_d = teach_diag_pkg::ST_HOLD;
        end
      teach_diag_pkg::ST_HOLD:
        if (!pressed)
        begin
          state_d = teach_diag_pkg::ST_IDLE;
        end
        else if (quickMode && holdReached)
        begin
          state_d = teach_diag_pkg::ST_TEACH;
        end
      teach_diag_pkg::ST_TEACH:
        if (measDone)
        begin
          state_d = measValid ? teach_diag_pkg::ST_IDLE : teach_diag_pkg::ST_FAIL;
        end
      teach_diag_pkg::ST_FAIL:
        if (failCount_q == FAIL_LAST)
        begin
          state_d = teach_diag_pkg::ST_IDLE;
        end
      default:
        state_d = teach_diag_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= teach_diag_pkg::ST_IDLE;
      holdCount_q <= '0;
      failCount_q <= '0;
      pressedPrev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pressedPrev_q <= pressed;
      holdCount_q <= !holdStep ? '0 : (&holdCount_q) ? holdCount_q : holdCount_q + 1'b1;
      failCount_q <= (state_q == teach_diag_pkg::ST_FAIL) ? failCount_q + 1'b1 : '0;
    end
  end

  // Quick teach ends on the measurement; expert teach ends on release
  assign teachEnd = ((state_q == teach_diag_pkg::ST_TEACH) && measDone) ||
                    expertFire;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      zeroPosition <= '0;
      zeroStored <= 1'b0;
      expertRequest <= teach_diag_pkg::REQ_NONE;
      expertRequestValid <= 1'b0;
    end
    else
    begin
      zeroStored <= 1'b0;
      expertRequestValid <= expertFire;
      if (expertFire)
      begin
        expertRequest <= expertFn3 ? teach_diag_pkg::REQ_FACTORY :
                         expertFn2 ? teach_diag_pkg::REQ_FIELD : teach_diag_pkg::REQ_ZERO;
      end
      if (state_q == teach_diag_pkg::ST_TEACH && measDone && measValid)
      begin
        zeroPosition <= measDistance;
        zeroStored <= 1'b1;
      end
    end
  end

  // Lock timer, restarted by each teach-in end, counted in minutes
  logic [MW-1:0] minCount_q;
  logic [7:0] minutes_q;
  logic timedOut_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      minCount_q <= '0;
      minutes_q <= '0;
      timedOut_q <= 1'b0;
    end
    else if (teachEnd || paramLockWrite)
    begin
      minCount_q <= '0;
      minutes_q <= '0;
      timedOut_q <= 1'b0;
    end
    // Frozen until a restart
    else if (!timedOut_q)
    begin
      minCount_q <= (minCount_q == MIN_LAST) ? '0 : minCount_q + 1'b1;
      if (minCount_q == MIN_LAST)
      begin
        minutes_q <= minutes_q + 1'b1;
        timedOut_q <= (minutes_q + 8'h01) >= lockTimeout;
      end
    end
  end

  // Zero means never lock; 255 means always locked
  assign buttonEnabled = (lockTimeout != teach_diag_pkg::LOCK_ALWAYS) &&
                         ((lockTimeout == teach_diag_pkg::LOCK_NEVER) || !timedOut_q);

  // Failure display counts as busy
  assign teachBusy = (state_q == teach_diag_pkg::ST_TEACH) ||
                     (state_q == teach_diag_pkg::ST_FAIL);

  // LED blink sources
  logic teachWave;
  logic failWave;
  logic critWave;

  logic critical;

  blink_gen #(.HALF_CYCLES(TEACH_HALF_CYCLES)) teachBlink (
    .clk(clk),
    .rstn(rstn),
    .enable(state_q == teach_diag_pkg::ST_TEACH),
    .wave(teachWave)
  );

  blink_gen #(.HALF_CYCLES(FAIL_HALF_CYCLES)) failBlink (
    .clk(clk),
    .rstn(rstn),
    .enable(state_q == teach_diag_pkg::ST_FAIL),
    .wave(failWave)
  );

  blink_gen #(.HALF_CYCLES(CRIT_HALF_CYCLES)) critBlink (
    .clk(clk),
    .rstn(rstn),
    .enable(critical),
    .wave(critWave)
  );

  // Measurement diagnostics
  meas_diag #(
    .SECOND_CYCLES(SECOND_CYCLES),
    .DIST_W(DIST_W),
    .RESERVE_W(RESERVE_W)
  ) diag (
    .clk(clk),
    .rstn(rstn),
    .measTrigger(measTrigger),
    .measDone(measDone),
    .measValid(measValid),
    .measDistance(measDistance),
    .measReserve(measReserve),
    .weakLimit(weakLimit),
    .criticalLimit(criticalLimit),
    .outValue(outValue),
    .outUpdate(outUpdate),
    .measurementRateValue(measurementRateValue),
    .responseDelayValue(responseDelayValue),
    .exposureReserve(exposureReserve),
    .signalQuality(signalQuality),
    .deviceHealthStatus(deviceHealthStatus),
    .alarmOut(alarmOut)
  );

  assign critical = (signalQuality == teach_diag_pkg::QUAL_CRITICAL);

  // Teach indication overrides status; yellow steady shows no value
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ledGreen <= 1'b0;
      ledYellow <= 1'b0;
    end
    else if (state_q == teach_diag_pkg::ST_TEACH)
    begin
      ledGreen <= teachWave;
      ledYellow <= 1'b0;
    end
    else if (state_q == teach_diag_pkg::ST_FAIL)
    begin
      ledGreen <= failWave;
      ledYellow <= failWave;
    end
    else if (critical)
    begin
      ledGreen <= critWave;
      ledYellow <= critWave;
    end
    else
    begin
      ledGreen <= ~alarmOut;
      ledYellow <= alarmOut;
    end
  end

endmodule

// File: teach_diag_monitor.sv
// Concurrent checks on the ports of the teach and diagnostic block.
// Assumes the bind in the bench and a single clock domain.
`timescale 1ns/1ps
module teach_diag_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Inputs watched
  input wire logic paramModeQuick,
  input wire logic paramModeWrite,
  input wire logic measTrigger,
  input wire logic measDone,
  input wire logic measValid,
  input wire logic [7:0] measReserve,
  input wire logic [7:0] criticalLimit,
  // Outputs watched
  input wire logic [7:0] lockTimeout,
  input wire logic buttonEnabled,
  input wire logic outUpdate,
  input wire logic [15:0] outValue,
  input wire logic [31:0] responseDelayValue,
  input wire logic alarmOut,
  input wire teach_diag_pkg::teach_mode_type teachMode,
  input wire teach_diag_pkg::quality_type signalQuality,
  input wire teach_diag_pkg::health_type deviceHealthStatus
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Trigger, two idle edges, then the result
  sequence s_delay3;
    measTrigger ##1 (!measDone) [*2] ##1 measDone;
  endsequence
  sequence s_bad_meas;
    measDone && !measValid;
  endsequence

  a_update_after_done: assert property (measDone |=> outUpdate)
    else $error("no update after done");
  a_update_has_cause: assert property (outUpdate |-> $past(measDone))
    else $error("update without done");
  a_delay_three: assert property (s_delay3 |=> responseDelayValue == 32'h0000_0003)
    else $error("response delay wrong");
  a_alarm_follows: assert property (measDone |=> alarmOut == !$past(measValid))
    else $error("alarm wrong");
  a_health_no_value: assert property (s_bad_meas |=> deviceHealthStatus == teach_diag_pkg::HEALTH_NO_VALUE)
    else $error("health wrong");
  a_value_kept: assert property (s_bad_meas |=> $stable(outValue))
    else $error("value changed on invalid");
  a_quality_critical: assert property (measDone && measValid && measReserve <= criticalLimit |=>
    signalQuality == teach_diag_pkg::QUAL_CRITICAL)
    else $error("quality not critical");
  a_mode_write: assert property (paramModeWrite |=> teachMode == $past(paramModeQuick))
    else $error("mode not taken");
  a_lock_never: assert property (lockTimeout == 8'h00 |-> buttonEnabled)
    else $error("button locked with zero timeout");
  a_lock_always: assert property (lockTimeout == 8'hFF |-> !buttonEnabled)
    else $error("button enabled with full lock");
endmodule

// File: meas_front_model.sv
// Behavioural optical front end: trigger, exposure wait, then result.
// Assumes go is a one-cycle request, never given while busy.
`timescale 1ns/1ps
module meas_front_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request from bench
  input wire logic go,
  input wire logic [7:0] expoCycles,
  input wire logic resValid,
  input wire logic [15:0] resDistance,
  input wire logic [7:0] resReserve,
  // Toward the block
  output logic measTrigger,
  output logic measDone,
  output logic measValid,
  output logic [15:0] measDistance,
  output logic [7:0] measReserve,
  output logic busy
);
  logic [7:0] stepCount_q;
  wire logic lastStep = busy && stepCount_q == 8'h01;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {measTrigger, measDone, measValid, busy} <= 4'h0;
      measDistance <= 16'h0000;
      measReserve <= 8'h00;
      stepCount_q <= 8'h00;
    end
    else
    begin
      measTrigger <= go;
      measDone <= lastStep;
      // Result lines are junk outside the done cycle
      measValid <= lastStep ? resValid : ~measValid;
      measDistance <= lastStep ? resDistance : ~measDistance;
      measReserve <= lastStep ? resReserve : ~measReserve;
      // Exposure length differs per request
      if (go)
      begin
        busy <= 1'h1;
        stepCount_q <= expoCycles;
      end
      else if (lastStep)
        busy <= 1'h0;
      else if (busy)
        stepCount_q <= stepCount_q - 8'h01;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench for the teach button and diagnostic block.
// Assumes the shortened timing parameters given to u_dut.
`timescale 1ns/1ps
`define CHK(w, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", w, e, g); end end
module tb;
  logic clk = 1'h0, rstn = 1'h0, buttonPin_n = 1'h1, paramModeQuick = 1'h0, paramModeWrite = 1'h0;
  logic paramLockWrite = 1'h0, go = 1'h0, resValid = 1'h0;
  logic [7:0] paramLockTimeout = 8'h00, weakLimit = 8'h40, criticalLimit = 8'h20, expoCycles = 8'h01;
  logic [7:0] resReserve = 8'h00, measReserve, lockTimeout, exposureReserve;
  logic [15:0] resDistance = 16'h0000, expOut = 16'h0000, measDistance, zeroPosition, outValue;
  logic [15:0] measurementRateValue;
  logic measTrigger, measDone, measValid, busy, buttonEnabled, zeroStored, expertRequestValid;
  logic teachBusy, ledGreen, ledYellow, outUpdate, alarmOut;
  logic [31:0] responseDelayValue;
  teach_diag_pkg::teach_mode_type teachMode;
  teach_diag_pkg::expert_req_type expertRequest;
  teach_diag_pkg::quality_type signalQuality;
  teach_diag_pkg::health_type deviceHealthStatus;
  int bad_count = 0, checks_done = 0, flips, e;
  time tPrev, tDone;

  meas_front_model u_front (.*);
  teach_button_and_diagnostic_status #(.HOLD_CYCLES(20), .MINUTE_CYCLES(50), .SECOND_CYCLES(100),
    .FAIL_SHOW_CYCLES(40), .TEACH_HALF_CYCLES(4), .FAIL_HALF_CYCLES(2), .CRIT_HALF_CYCLES(3)) u_dut (.*);

  function automatic teach_diag_pkg::quality_type qexp(logic [7:0] r);
    if (r <= criticalLimit) return teach_diag_pkg::QUAL_CRITICAL;
    if (r <= weakLimit) return teach_diag_pkg::QUAL_WEAK;
    return teach_diag_pkg::QUAL_VALID;
  endfunction

  function automatic teach_diag_pkg::health_type hexp(logic v, logic [7:0] r);
    if (!v) return teach_diag_pkg::HEALTH_NO_VALUE;
    if (r <= criticalLimit) return teach_diag_pkg::HEALTH_MAINT;
    return teach_diag_pkg::HEALTH_OK;
  endfunction

  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic meas(logic v, logic [15:0] d, logic [7:0] r, logic [7:0] x);
    go = 1'h1; expoCycles = x; resValid = v; resDistance = d; resReserve = r;
    tick(1);
    go = 1'h0;
    repeat (300) begin tick(1); if (measDone === 1'h1) break; end
    tPrev = tDone;
    tDone = $time;
    tick(1);
    if (v) expOut = d;
    `CHK("update", 1'h1, outUpdate)
    `CHK("value", expOut, outValue)
    `CHK("delay", {24'h00_0000, x}, responseDelayValue)
    `CHK("alarm", !v, alarmOut)
    `CHK("health", hexp(v, r), deviceHealthStatus)
    if (v) `CHK("quality", qexp(r), signalQuality)
    if (v) `CHK("reserve", r, exposureReserve)
  endtask

  task automatic setLock(logic [7:0] m);
    paramLockTimeout = m; paramLockWrite = 1'h1;
    tick(1);
    paramLockWrite = 1'h0;
    tick(1);
  endtask

  task automatic press(int n);
    buttonPin_n = 1'($urandom);
    tick(1);
    buttonPin_n = 1'h0;
    tick(n);
    buttonPin_n = 1'h1;
  endtask

  task automatic expect_req(int n, teach_diag_pkg::expert_req_type q);
    logic seen;
    seen = 1'h0;
    press(n);
    repeat (8) begin tick(1); if (expertRequestValid === 1'h1) begin seen = 1'h1; break; end end
    `CHK("request seen", q != teach_diag_pkg::REQ_NONE, seen)
    if (seen) `CHK("request", q, expertRequest)
    tick(5);
  endtask

  // Counts green edges; yellow must track green or stay dark
  task automatic blink(int n, logic both);
    logic prev;
    flips = 0;
    prev = ledGreen;
    repeat (n)
    begin
      tick(1);
      if (ledGreen !== prev) flips++;
      prev = ledGreen;
      if (both) `CHK("in phase", ledGreen, ledYellow)
      else `CHK("yellow dark", 1'h0, ledYellow)
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // Whole run needs well under 3000 cycles
  initial
  begin
    #(5 * 20000);
    bad_count++;
    report_and_stop;
  end

  initial
  begin
    void'($urandom(31594));
    criticalLimit = 8'($urandom_range(48, 16));
    weakLimit = criticalLimit + 8'h20;
    repeat (5) @(negedge clk);
    rstn = 1'h1;
    tick(1);
    `CHK("reset mode", teach_diag_pkg::MODE_EXPERT, teachMode)
    `CHK("reset timeout", 8'h05, lockTimeout)
    `CHK("reset enable", 1'h1, buttonEnabled)
    setLock(8'h00);
    meas(1'h1, 16'h1234, criticalLimit, 8'h03);
    meas(1'h1, 16'h4321, weakLimit, 8'h01);
    meas(1'h0, 16'hBEEF, 8'hFF, 8'h02);
    repeat (24) meas(1'($urandom_range(1)), 16'($urandom), 8'($urandom), 8'($urandom_range(8, 1)));
    $display("test measurement done");
    repeat (40) meas(1'h1, 16'($urandom), 8'hF0, 8'h04);
    e = int'((tDone - tPrev) / 5);
    e = 100 / e;
    `CHK("rate", 1'h1, measurementRateValue >= 16'(e) && measurementRateValue <= 16'(e + 1))
    $display("test rate done");
    expect_req(10, teach_diag_pkg::REQ_NONE);
    expect_req(30, teach_diag_pkg::REQ_ZERO);
    expect_req(50, teach_diag_pkg::REQ_FIELD);
    expect_req(70, teach_diag_pkg::REQ_FACTORY);
    $display("test expert done");
    paramModeQuick = 1'h1; paramModeWrite = 1'h1;
    tick(1);
    paramModeWrite = 1'h0;
    paramModeQuick = 1'($urandom);
    tick(1);
    `CHK("quick mode", teach_diag_pkg::MODE_QUICK, teachMode)
    press(10);
    tick(4);
    `CHK("short press", 1'h0, teachBusy)
    expect_req(30, teach_diag_pkg::REQ_NONE);
    `CHK("teach busy", 1'h1, teachBusy)
    blink(16, 1'h0);
    `CHK("teach blink", 1'h1, flips >= 3)
    meas(1'h1, 16'h0ABC, 8'hF0, 8'h02);
    `CHK("zero pulse", 1'h1, zeroStored)
    `CHK("zero stored", 16'h0ABC, zeroPosition)
    tick(2);
    `CHK("teach end", 1'h0, teachBusy)
    press(30);
    tick(4);
    meas(1'h0, 16'h5555, 8'h00, 8'h02);
    `CHK("no zero pulse", 1'h0, zeroStored)
    tick(2);
    blink(16, 1'h1);
    `CHK("fail blink", 1'h1, flips >= 6)
    `CHK("zero kept", 16'h0ABC, zeroPosition)
    repeat (60) begin tick(1); if (teachBusy === 1'h0) break; end
    `CHK("fail end", 1'h0, teachBusy)
    $display("test quick done");
    setLock(8'h01);
    tick(40);
    `CHK("lock early", 1'h1, buttonEnabled)
    tick(20);
    `CHK("lock expired", 1'h0, buttonEnabled)
    setLock(8'hFF);
    `CHK("lock always", 1'h0, buttonEnabled)
    press(30);
    tick(4);
    `CHK("locked press", 1'h0, teachBusy)
    setLock(8'h00);
    `CHK("lock never", 1'h1, buttonEnabled)
    meas(1'h1, 16'h0100, 8'h00, 8'h02);
    tick(2);
    blink(14, 1'h1);
    `CHK("critical blink", 1'h1, flips >= 2)
    $display("test lock done");
    report_and_stop;
  end
endmodule

bind teach_button_and_diagnostic_status teach_diag_monitor u_mon (.*);
